// >>> afe_cfg_pkg.sv
package afe_cfg_pkg;

    // ****************************************************************
    // register offsets on the serial register port
    // ****************************************************************
    localparam logic [7:0] OFS_MAIN = 8'h00;
    localparam logic [7:0] OFS_CLAMP_REF = 8'h04;
    localparam logic [7:0] OFS_SAMPLE_HOLD = 8'h06;
    localparam logic [7:0] OFS_GAIN1 = 8'h10;
    localparam logic [7:0] OFS_GAIN2 = 8'h11;
    localparam logic [7:0] OFS_COARSE1 = 8'h12;
    localparam logic [7:0] OFS_FINE1 = 8'h13;
    localparam logic [7:0] OFS_COARSE2 = 8'h14;
    localparam logic [7:0] OFS_FINE2 = 8'h15;
    localparam logic [7:0] OFS_SIGN = 8'h16;
    localparam logic [7:0] OFS_SWING = 8'h17;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_CLAMP_START = 8'h20;
    localparam logic [7:0] OFS_CLAMP_END = 8'h21;
    localparam logic [7:0] OFS_SAMPLE_START = 8'h22;
    localparam logic [7:0] OFS_SAMPLE_END = 8'h23;

    // ****************************************************************
    // storage indices, field positions and reset values
    // ****************************************************************
    localparam int NREG = 15;
    localparam int IX_MAIN = 0;
    localparam int IX_CLREF = 1;
    localparam int IX_SH = 2;
    localparam int IX_CLS = 3;
    localparam int IX_CLE = 4;
    localparam int IX_SMS = 5;
    localparam int IX_SME = 6;
    localparam int IX_G1 = 7;
    localparam int IX_SIGN = 13;
    localparam int IX_SWING = 14;
    localparam int BIT_CDS = 0;
    localparam int BIT_GAIN6 = 2;
    localparam int BIT_FINE_EN = 5;
    localparam int BIT_COARSE_EN = 6;
    localparam int BIT_SH_EN = 7;
    localparam logic [7:0] RST_SH = 8'h80;
    localparam logic [7:0] MASK_CLREF = 8'h1F;
    localparam logic [7:0] MASK_EDGE = 8'h3F;
    localparam logic [7:0] MASK_SWING = 8'h03;
    localparam logic [8:0] OFFSET_ZERO = 9'h0_FF;

    // ****************************************************************
    // timing: pixel period limits at the 8 ns system clock
    // ****************************************************************
    localparam int CLK_NS = 8;
    localparam int PIX_MIN_NS = 25;
    localparam int PIX_MAX_NS = 200;
    localparam int PIX_MIN_CYC = (PIX_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int PIX_MAX_CYC = PIX_MAX_NS / CLK_NS;
    localparam int RECOVER_PIX = 2;
    localparam int EDGES = 64;

endpackage

// >>> afe_signal_path_config.sv
`timescale 1ns/1ps

// Contract
// - gated clamp is internal clamp AND pin
// - sample-hold: pin in black closes switch; code closes it only inside the clamp pulse window
// - five-bit clamp reference code from register
// - main bit 2 sets 6 dB, both channels
// - each channel has its own gain code
// - coarse and fine offset, 8 bit plus sign
// - offset applies only when enable bits set
// - offset codes are 9-bit offset binary
// - coarse up to 2048, fine up to 41
// - offset applied to video level sample
// - pixel rate between 5 and 40 MSPS
// - valid conversions two pixels after overrange
// - selectable differential output swing setting
// - double sampling needs hold off, cds set
// - pulses on 64-edge grid, start/end registers
module afe_signal_path_config #(
    parameter int DATA_W = 14,
    parameter int CORR_W = 13
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // register port from the serial interface
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // sensor side
    input wire logic pixel_strobe,
    input wire logic external_clamp_input,
    input wire logic adc_out_of_range,
    // analog controls
    output logic gated_clamp_control,
    output logic input_clamp_switch,
    output logic clamp_pulse,
    output logic sample_pulse,
    output logic [4:0] clamp_reference_voltage,
    output logic sampling_gain_6db,
    output logic cds_mode,
    output logic [7:0] channel_one_gain_code,
    output logic [7:0] channel_two_gain_code,
    output logic signed [CORR_W-1:0] ch1_offset_corr,
    output logic signed [CORR_W-1:0] ch2_offset_corr,
    output logic video_offset_apply,
    output logic [1:0] differential_output_swing,
    // converter status
    output logic data_valid,
    output logic rate_ok
);

    // ****************************************************************
    // address decode, used by write and read paths
    // ****************************************************************
    function automatic logic [4:0] decode(input logic [7:0] a);
        // returns {hit, index}; index is unused on a miss
        case (a)
            afe_cfg_pkg::OFS_MAIN: decode = 5'h10;
            afe_cfg_pkg::OFS_CLAMP_REF: decode = 5'h11;
            afe_cfg_pkg::OFS_SAMPLE_HOLD: decode = 5'h12;
            afe_cfg_pkg::OFS_CLAMP_START: decode = 5'h13;
            afe_cfg_pkg::OFS_CLAMP_END: decode = 5'h14;
            afe_cfg_pkg::OFS_SAMPLE_START: decode = 5'h15;
            afe_cfg_pkg::OFS_SAMPLE_END: decode = 5'h16;
            afe_cfg_pkg::OFS_GAIN1: decode = 5'h17;
            afe_cfg_pkg::OFS_GAIN2: decode = 5'h18;
            afe_cfg_pkg::OFS_COARSE1: decode = 5'h19;
            afe_cfg_pkg::OFS_FINE1: decode = 5'h1A;
            afe_cfg_pkg::OFS_COARSE2: decode = 5'h1B;
            afe_cfg_pkg::OFS_FINE2: decode = 5'h1C;
            afe_cfg_pkg::OFS_SIGN: decode = 5'h1D;
            afe_cfg_pkg::OFS_SWING: decode = 5'h1E;
            default: decode = 5'h00;
        endcase
    endfunction

    // pulse window on the edge grid, wrapping when start > end
    function automatic logic in_window(input logic [5:0] e,
                                       input logic [5:0] s,
                                       input logic [5:0] f);
        if (s <= f) begin
            in_window = (e >= s) && (e <= f);
        end else begin
            in_window = (e >= s) || (e <= f);
        end
    endfunction

    // write mask keeps narrow fields narrow
    function automatic logic [7:0] wmask(input logic [3:0] ix);
        case (ix)
            4'(afe_cfg_pkg::IX_CLREF): wmask = afe_cfg_pkg::MASK_CLREF;
            4'(afe_cfg_pkg::IX_CLS): wmask = afe_cfg_pkg::MASK_EDGE;
            4'(afe_cfg_pkg::IX_CLE): wmask = afe_cfg_pkg::MASK_EDGE;
            4'(afe_cfg_pkg::IX_SMS): wmask = afe_cfg_pkg::MASK_EDGE;
            4'(afe_cfg_pkg::IX_SME): wmask = afe_cfg_pkg::MASK_EDGE;
            4'(afe_cfg_pkg::IX_SIGN): wmask = 8'h0F;
            4'(afe_cfg_pkg::IX_SWING): wmask = afe_cfg_pkg::MASK_SWING;
            default: wmask = 8'hFF;
        endcase
    endfunction

    // ****************************************************************
    // register file
    // ****************************************************************
    logic [7:0] regs_q [afe_cfg_pkg::NREG]; // written values
    logic [7:0] regs_d [afe_cfg_pkg::NREG];
    logic [7:0] act_q [afe_cfg_pkg::NREG]; // values in force
    logic [7:0] act_d [afe_cfg_pkg::NREG];
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic [4:0] wdec; // decoded write address
    logic [4:0] rdec; // decoded read address

    assign wdec = decode(reg_addr);
    assign rdec = decode(reg_addr);

    // writes land in the shadow; the active copy follows at a pixel
    always_comb begin
        regs_d = regs_q;
        act_d = act_q;
        if (reg_wr && wdec[4]) begin
            regs_d[wdec[3:0]] = reg_wdata & wmask(wdec[3:0]);
        end
        if (pixel_strobe) begin
            act_d = regs_d;
        end
    end

    // read returns the shadow, status is live, unmapped reads zero
    always_comb begin
        rdata_d = rdata_q;
        if (reg_rd) begin
            if (rdec[4]) begin
                rdata_d = regs_q[rdec[3:0]];
            end else if (reg_addr == afe_cfg_pkg::OFS_STATUS) begin
                rdata_d = {5'h00, rate_ok, data_valid, cds_mode};
            end else begin
                rdata_d = 8'h00;
            end
        end
    end

    // register update; hold enable defaults on, everything else off
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < afe_cfg_pkg::NREG; i++) begin
                regs_q[i] <= 8'h00;
                act_q[i] <= 8'h00;
            end
            regs_q[afe_cfg_pkg::IX_SH] <= afe_cfg_pkg::RST_SH;
            act_q[afe_cfg_pkg::IX_SH] <= afe_cfg_pkg::RST_SH;
            rdata_q <= 8'h00;
        end else begin
            regs_q <= regs_d;
            act_q <= act_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    // ****************************************************************
    // pixel timing: edge grid, rate check, overrange recovery
    // ****************************************************************
    logic [7:0] cnt_q; // clocks since last pixel, saturating
    logic [7:0] cnt_d;
    logic rate_q;
    logic rate_d;
    logic [1:0] recov_q; // pixels still to wait after overrange
    logic [1:0] recov_d;
    logic [5:0] grid_edge;

    always_comb begin
        cnt_d = cnt_q;
        rate_d = rate_q;
        recov_d = recov_q;
        if (pixel_strobe) begin
            cnt_d = 8'h00;
            rate_d = (cnt_q >= 8'(afe_cfg_pkg::PIX_MIN_CYC - 1)) &&
                     (cnt_q <= 8'(afe_cfg_pkg::PIX_MAX_CYC - 1));
            if (recov_q != 2'h0) begin
                recov_d = recov_q - 2'h1;
            end
        end else if (cnt_q != 8'hFF) begin
            cnt_d = cnt_q + 8'h01;
        end
        if (adc_out_of_range) begin
            recov_d = 2'(afe_cfg_pkg::RECOVER_PIX);
        end
    end

    // timing state; rate is assumed bad until a pixel is measured
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_q <= 8'h00;
            rate_q <= 1'b0;
            recov_q <= 2'h0;
        end else begin
            cnt_q <= cnt_d;
            rate_q <= rate_d;
            recov_q <= recov_d;
        end
    end

    assign grid_edge = (cnt_q > 8'(afe_cfg_pkg::EDGES - 1)) ?
                       6'h3F : cnt_q[5:0];
    assign rate_ok = rate_q;
    assign data_valid = (recov_q == 2'h0);

    // ****************************************************************
    // clamp and sample pulses
    // ****************************************************************
    // edge windows
    assign clamp_pulse = in_window(grid_edge,
                                   act_q[afe_cfg_pkg::IX_CLS][5:0],
                                   act_q[afe_cfg_pkg::IX_CLE][5:0]);
    assign sample_pulse = in_window(grid_edge,
                                    act_q[afe_cfg_pkg::IX_SMS][5:0],
                                    act_q[afe_cfg_pkg::IX_SME][5:0]);
    assign gated_clamp_control = clamp_pulse & external_clamp_input;
    assign cds_mode =
        act_q[afe_cfg_pkg::IX_MAIN][afe_cfg_pkg::BIT_CDS] &
        ~act_q[afe_cfg_pkg::IX_SH][afe_cfg_pkg::BIT_SH_EN];
    assign input_clamp_switch = ~cds_mode & gated_clamp_control;

    // ****************************************************************
    // static controls, and the offset apply strobe
    // ****************************************************************
    // clamp reference
    assign clamp_reference_voltage = act_q[afe_cfg_pkg::IX_CLREF][4:0];
    assign sampling_gain_6db =
        act_q[afe_cfg_pkg::IX_MAIN][afe_cfg_pkg::BIT_GAIN6];
    assign differential_output_swing = act_q[afe_cfg_pkg::IX_SWING][1:0];
    assign video_offset_apply = sample_pulse;

    // ****************************************************************
    // per-channel gain and offset correction
    // ****************************************************************
    logic [7:0] gain [2];
    logic signed [CORR_W-1:0] corr [2];
    logic coarse_en;
    logic fine_en;

    assign coarse_en =
        act_q[afe_cfg_pkg::IX_MAIN][afe_cfg_pkg::BIT_COARSE_EN];
    assign fine_en = act_q[afe_cfg_pkg::IX_MAIN][afe_cfg_pkg::BIT_FINE_EN];

    for (genvar c = 0; c < 2; c++) begin : g_chan
        logic [8:0] ccode; // coarse 9-bit code in force
        logic [8:0] fcode;
        logic signed [9:0] cdev; // deviation from zero code
        logic signed [9:0] fdev;
        logic signed [16:0] fprod;
        assign gain[c] = act_q[afe_cfg_pkg::IX_G1 + c];
        assign ccode = {act_q[afe_cfg_pkg::IX_SIGN][2 * c],
                        act_q[afe_cfg_pkg::IX_G1 + 2 + 2 * c]};
        assign fcode = {act_q[afe_cfg_pkg::IX_SIGN][2 * c + 1],
                        act_q[afe_cfg_pkg::IX_G1 + 3 + 2 * c]};
        assign cdev = coarse_en ?
            $signed({1'b0, ccode}) - $signed({1'b0, afe_cfg_pkg::OFFSET_ZERO})
            : 10'sh000;
        assign fdev = fine_en ?
            $signed({1'b0, fcode}) - $signed({1'b0, afe_cfg_pkg::OFFSET_ZERO})
            : 10'sh000;
        assign fprod = 17'(fdev * 17'sd41);
        assign corr[c] = CORR_W'((cdev <<< 3) + (fprod >>> 8));
    end

    assign channel_one_gain_code = gain[0];
    assign channel_two_gain_code = gain[1];
    assign ch1_offset_corr = corr[0];
    assign ch2_offset_corr = corr[1];

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    AST_GATE: assert property (gated_clamp_control ==
        (clamp_pulse && external_clamp_input))
        else $error("gated clamp is not the and of its inputs");
    AST_SWITCH: assert property (input_clamp_switch |->
        (!cds_mode && external_clamp_input))
        else $error("clamp switch closed outside hold mode");
    AST_CLREF: assert property ((reg_wr && reg_addr ==
        afe_cfg_pkg::OFS_CLAMP_REF) ##1 (pixel_strobe && !reg_wr) |=>
        clamp_reference_voltage == $past(reg_wdata[4:0], 2))
        else $error("clamp reference not taken from write");
    AST_GAIN6: assert property (sampling_gain_6db ==
        act_q[afe_cfg_pkg::IX_MAIN][2])
        else $error("sampling gain not from main bit 2");
    AST_OFF_DIS: assert property (!coarse_en && !fine_en |->
        ch1_offset_corr == 0 && ch2_offset_corr == 0)
        else $error("offset applied while disabled");
    AST_RANGE: assert property (ch1_offset_corr <= 2089 &&
        ch1_offset_corr >= -2089)
        else $error("offset beyond coarse plus fine range");
    AST_APPLY: assert property (video_offset_apply == sample_pulse)
        else $error("offset applied outside video sample");
    AST_RATE: assert property (pixel_strobe &&
        cnt_q < 8'(afe_cfg_pkg::PIX_MIN_CYC - 1) |=> !rate_ok)
        else $error("too fast pixel rate accepted");
    AST_RECOV: assert property (adc_out_of_range |=>
        !data_valid [*2])
        else $error("valid too early after overrange");
    AST_CDS: assert property (cds_mode |->
        !act_q[afe_cfg_pkg::IX_SH][7] && act_q[afe_cfg_pkg::IX_MAIN][0])
        else $error("double sampling entered illegally");
    AST_HOLD: assert property (!pixel_strobe |=>
        $stable(channel_one_gain_code) && $stable(sampling_gain_6db))
        else $error("setting changed between pixels");

    COV_CLAMP: cover property (gated_clamp_control ##1 !clamp_pulse);
    COV_OVR: cover property (adc_out_of_range ##[1:200] data_valid);
    COV_CDS: cover property (!cds_mode ##1 cds_mode);

endmodule

// >>> afe_signal_path_config_test.sv
`timescale 1ns/1ps

module afe_signal_path_config_test;
    // ****************************************************************
    // signals
    // ****************************************************************
    logic mclk, rst, reg_wr, reg_rd, black, ovr_req; // bench drives
    logic [7:0] reg_addr, reg_wdata, reg_rdata, period;
    logic pixel_strobe, external_clamp_input, adc_out_of_range;
    logic gated_clamp_control, input_clamp_switch, clamp_pulse;
    logic sample_pulse, sampling_gain_6db, cds_mode;
    logic video_offset_apply, data_valid, rate_ok;
    logic [4:0] clamp_reference_voltage;
    logic [7:0] channel_one_gain_code, channel_two_gain_code;
    logic signed [12:0] ch1_offset_corr, ch2_offset_corr;
    logic [1:0] differential_output_swing;
    int err_total, n_compared, hits;
    logic win; // clamp window expected at the current grid edge
    typedef struct { logic [7:0] a, d, r; } row_t; // addr, write, read
    // register rows: clipped fields read back as zeros
    row_t rows[16] = '{'{8'h00, 8'h65, 8'h65}, '{8'h04, 8'hFF, 8'h1F},
        '{8'h06, 8'h00, 8'h00}, '{8'h10, 8'hA5, 8'hA5},
        '{8'h11, 8'h5A, 8'h5A}, '{8'h12, 8'h7F, 8'h7F},
        '{8'h13, 8'hFF, 8'hFF}, '{8'h14, 8'h00, 8'h00},
        '{8'h15, 8'h7F, 8'h7F}, '{8'h16, 8'hFB, 8'h0B},
        '{8'h17, 8'hFE, 8'h02}, '{8'h20, 8'hC2, 8'h02},
        '{8'h21, 8'h05, 8'h05}, '{8'h22, 8'h06, 8'h06},
        '{8'h23, 8'h07, 8'h07}, '{8'h30, 8'hAA, 8'h00}};
    logic [7:0] modes[4] = '{8'h65, 8'h41, 8'h24, 8'h00};
    logic [7:0] pers[4] = '{8'h03, 8'h04, 8'h19, 8'h1A};
    logic okr[4] = '{1'h0, 1'h1, 1'h1, 1'h0}; // rate limits 4..25

    // ****************************************************************
    // design and sensor
    // ****************************************************************
    afe_signal_path_config dut_u (.mclk(mclk), .rst(rst),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .pixel_strobe(pixel_strobe),
        .external_clamp_input(external_clamp_input),
        .adc_out_of_range(adc_out_of_range),
        .gated_clamp_control(gated_clamp_control),
        .input_clamp_switch(input_clamp_switch),
        .clamp_pulse(clamp_pulse), .sample_pulse(sample_pulse),
        .clamp_reference_voltage(clamp_reference_voltage),
        .sampling_gain_6db(sampling_gain_6db), .cds_mode(cds_mode),
        .channel_one_gain_code(channel_one_gain_code),
        .channel_two_gain_code(channel_two_gain_code),
        .ch1_offset_corr(ch1_offset_corr),
        .ch2_offset_corr(ch2_offset_corr),
        .video_offset_apply(video_offset_apply),
        .differential_output_swing(differential_output_swing),
        .data_valid(data_valid), .rate_ok(rate_ok));
    sensor_model sensor_u (.mclk(mclk), .rst(rst), .period(period),
        .black(black), .ovr_req(ovr_req), .pixel_strobe(pixel_strobe),
        .external_clamp_input(external_clamp_input),
        .adc_out_of_range(adc_out_of_range));

    // ****************************************************************
    // helpers
    // ****************************************************************
    // compare, count and report
    task automatic chk(input logic [15:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge mclk);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'h0;
    endtask
    // read data is settled just after the same edge that takes the strobe
    task automatic rdchk(input logic [7:0] a, exp);
        @(posedge mclk);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'h0;
        #1 chk(reg_rdata, exp);
    endtask
    // wait for a strobe, bounded, then let the settings land
    task automatic wait_pix;
        int i;
        i = 0;
        do begin
            @(posedge mclk);
            i++;
        end while (pixel_strobe !== 1'h1 && i < 64);
        if (i >= 64) begin
            err_total++;
            $display("ERROR at %0t: no pixel strobe", $time);
        end
        @(posedge mclk);
        #1;
    endtask
    // expected correction: offset binary, zero at 0 1111 1111
    function automatic logic signed [12:0] corr(input logic [8:0] c, f,
            input logic [7:0] m);
        int v;
        v = 0;
        if (m[6]) v += (int'(c) - int'(afe_cfg_pkg::OFFSET_ZERO)) * 8;
        if (m[5]) v += ((int'(f) - int'(afe_cfg_pkg::OFFSET_ZERO)) * 41) >>> 8;
        return v[12:0];
    endfunction
    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ****************************************************************
    // clock, watchdog, tests
    // ****************************************************************
    initial begin
        mclk = 1'h0;
        forever #4 mclk = ~mclk;
    end
    // whole run is several hundred cycles; this is far beyond it
    initial begin
        #400000;
        err_total++;
        stop_test;
    end
    initial begin
        {rst, reg_wr, reg_rd, black, ovr_req} = 5'h10;
        {reg_addr, reg_wdata, period} = {8'h00, 8'h00, 8'h14};
        err_total = 0;
        n_compared = 0;
        hits = 0;
        repeat (2) @(posedge mclk);
        rst <= 1'h0;
        // reset values
        rdchk(8'h06, afe_cfg_pkg::RST_SH);
        rdchk(8'h00, 8'h00);
        chk({data_valid, rate_ok, cds_mode}, 3'h4);
        $display("test reset done");
        // table: write then read back each register
        foreach (rows[k]) begin
            wr(rows[k].a, rows[k].d);
            rdchk(rows[k].a, rows[k].r);
        end
        wait_pix;
        chk(clamp_reference_voltage, 5'h1F);
        chk({channel_one_gain_code, channel_two_gain_code}, 16'hA55A);
        chk(differential_output_swing, 2'h2);
        $display("test registers done");
        // enable and sign combinations of the offset dacs
        foreach (modes[k]) begin
            wr(8'h00, modes[k]);
            wait_pix;
            chk(ch1_offset_corr, corr(9'h17F, 9'h1FF, modes[k]));
            chk(ch2_offset_corr, corr(9'h000, 9'h17F, modes[k]));
            chk(sampling_gain_6db, modes[k][2]);
            chk(cds_mode, modes[k][0]);
        end
        wr(8'h00, 8'h65);
        wait_pix;
        // coarse +1024 with fine +41; coarse -2040 with fine +20
        chk(ch1_offset_corr, 13'sh0429);
        chk(ch2_offset_corr, 13'sh181C);
        $display("test offsets done");
        // hold bit set blocks double sampling even with bit 0 set
        wr(8'h06, 8'h80);
        wr(8'h00, 8'h01);
        wait_pix;
        chk(cds_mode, 1'h0);
        // clamp gating over black and active pixels; grid is 1 here and
        // the pin follows black one clock late, so it is high for 1..20
        for (int i = 0; i < 40; i++) begin
            @(posedge mclk);
            black <= (i < 20);
            #1;
            win = ((i + 2) % 20) inside {[2:5]};
            chk(clamp_pulse, win);
            chk(sample_pulse, ((i + 2) % 20) inside {[6:7]});
            chk(gated_clamp_control, win && (i inside {[1:20]}));
            chk(input_clamp_switch, win && (i inside {[1:20]}));
            chk(video_offset_apply, sample_pulse);
            hits += gated_clamp_control;
        end
        chk(hits != 0, 1'h1);
        $display("test clamp done");
        // new gain waits for the next pixel
        wait_pix;
        wr(8'h10, 8'h3C);
        #1 chk(channel_one_gain_code, 8'hA5);
        wait_pix;
        chk(channel_one_gain_code, 8'h3C);
        $display("test pixel update done");
        // overrange then two pixels of recovery
        @(posedge mclk);
        ovr_req <= 1'h1;
        @(posedge mclk);
        ovr_req <= 1'h0;
        @(posedge mclk);
        #1 chk(data_valid, 1'h0);
        wait_pix;
        chk(data_valid, 1'h0);
        wait_pix;
        chk(data_valid, 1'h1);
        wr(8'h18, 8'hFF);
        rdchk(8'h18, 8'h06);
        $display("test overrange done");
        // pixel rate limits; the reference write lands on a strobe edge at period 3
        // and one clock before a strobe at period 4, and must still reach the pin
        foreach (pers[k]) begin
            period <= pers[k];
            repeat (3) wait_pix;
            chk(rate_ok, okr[k]);
            wr(8'h04, pers[k]);
            wait_pix;
            chk(clamp_reference_voltage, pers[k][4:0]);
        end
        $display("test rate done");
        // second reset in mid-run
        @(posedge mclk);
        rst <= 1'h1;
        repeat (2) @(posedge mclk);
        rst <= 1'h0;
        #1 chk(channel_one_gain_code, 8'h00);
        rdchk(8'h10, 8'h00);
        $display("test reset again done");
        stop_test;
    end
endmodule

// >>> sensor_model.sv
`timescale 1ns/1ps

// ****************************************************************
// image sensor model: pixel strobe, clamp pin, overrange flag
// ****************************************************************
module sensor_model (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // controls from the bench
    input wire logic [7:0] period,
    input wire logic black,
    input wire logic ovr_req,
    // sensor outputs
    output logic pixel_strobe,
    output logic external_clamp_input,
    output logic adc_out_of_range
);
    logic [7:0] cnt_q; // clocks into the current pixel
    logic wrap; // last clock of this pixel

    // >= so that a shorter period set mid-pixel still wraps at once
    assign wrap = (cnt_q >= period - 8'h01);

    // all outputs move just after the edge, like a real sensor
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_q <= 8'h00;
            pixel_strobe <= 1'h0;
            external_clamp_input <= 1'h0;
            adc_out_of_range <= 1'h0;
        end else begin
            pixel_strobe <= wrap;
            cnt_q <= wrap ? 8'h00 : cnt_q + 8'h01;
            external_clamp_input <= black;
            adc_out_of_range <= ovr_req;
        end
    end
endmodule
